//--- include/caom_pkg.sv
// Purpose: Shared modes, constants and decode helpers for the operand
//          addressing-mode engine.
// Assumes: 8-bit data, 16-bit address space, word values held MSB first.
// Notes:   Mode codes name the form before any indirect prefix is applied.
package caom_pkg;

	// Page zero occupies the low 256 bytes of the address space.
	localparam logic [7:0] PAGE0_HI = 8'h00;
	// Prefix byte values.
	localparam logic [7:0] PFX_INDIRECT = 8'h92;
	localparam logic [7:0] PFX_ALTERNATE = 8'h90;
	// One opcode byte, and the step from one byte address to the next.
	localparam logic [2:0] OPC_LEN = 3'h1;
	localparam logic [15:0] ADDR_STEP = 16'h0001;
	localparam logic [7:0] BYTE_STEP = 8'h01;
	// Highest address that short indexed forms can reach.
	localparam logic [15:0] IDX_SHORT_MAX = 16'h01FE;
	// Bias that folds the relative range onto 0 to FF.
	localparam logic [15:0] REL_BIAS = 16'h0080;
	localparam logic [15:0] REL_SPAN = 16'h00FF;

	// The seventeen addressing modes.
	typedef enum logic [4:0] {
		AM_INH, AM_IMM, AM_DIR_S, AM_DIR_L, AM_IDX0, AM_IDX_S, AM_IDX_L,
		AM_IND_S, AM_IND_L, AM_IIX_S, AM_IIX_L, AM_REL_D, AM_REL_I,
		AM_BIT_D, AM_BIT_I, AM_BIT_R, AM_BIT_RI
	} caom_mode_e;

	// Maps a direct or indexed form onto its indirect counterpart.
	function automatic caom_mode_e with_indirect(input caom_mode_e m);
		case (m)
			AM_DIR_S: return AM_IND_S;
			AM_DIR_L: return AM_IND_L;
			AM_IDX_S: return AM_IIX_S;
			AM_IDX_L: return AM_IIX_L;
			AM_REL_D: return AM_REL_I;
			AM_BIT_D: return AM_BIT_I;
			AM_BIT_R: return AM_BIT_RI;
			default: return m;
		endcase
	endfunction

	// Number of bytes that follow the opcode.
	function automatic logic [1:0] fetch_count(input caom_mode_e m);
		case (m)
			AM_INH, AM_IDX0: return 2'h0;
			AM_DIR_L, AM_IDX_L, AM_BIT_R, AM_BIT_RI: return 2'h2;
			default: return 2'h1;
		endcase
	endfunction

	// Number of pointer bytes read from page zero.
	function automatic logic [1:0] ptr_count(input caom_mode_e m);
		case (m)
			AM_IND_S, AM_IIX_S, AM_REL_I, AM_BIT_I, AM_BIT_RI: return 2'h1;
			AM_IND_L, AM_IIX_L: return 2'h2;
			default: return 2'h0;
		endcase
	endfunction

	// True for the forms that reach the whole 64 Kbyte space.
	function automatic logic is_long(input caom_mode_e m);
		return m inside {AM_DIR_L, AM_IDX_L, AM_IND_L, AM_IIX_L};
	endfunction

	// Adds a signed 8-bit displacement to the next-instruction address.
	function automatic logic [15:0] rel_target(input logic [15:0] pc,
		input logic [7:0] d);
		return pc + {{8{d[7]}}, d};
	endfunction

endpackage

//--- include/caom_agen_if.sv
// Purpose: Carries gathered bytes to the address adder and results back.
// Assumes: Purely combinational path within one clock domain.
// Notes:   The control side drives inputs, the adder drives ea and target.
`timescale 1ns/1ps
interface caom_agen_if;
	caom_pkg::caom_mode_e mode;
	logic [7:0] b0;
	logic [7:0] b1;
	logic [7:0] p0;
	logic [7:0] p1;
	logic [7:0] idx;
	logic [15:0] pcn;
	logic [15:0] ea;
	logic [15:0] target;
	modport ctl (output mode, b0, b1, p0, p1, idx, pcn, input ea, target);
	modport agen (input mode, b0, b1, p0, p1, idx, pcn, output ea, target);
endinterface

//--- src/caom_agen.sv
// Purpose: Forms the effective operand address and the relative target.
// Assumes: Bytes arrive already gathered, words most significant first.
// Notes:   Combinational only; the caller registers the results.
`timescale 1ns/1ps
module caom_agen (
	// Gathered operand bytes in, addresses out.
	caom_agen_if.agen a
);

	// Address arithmetic for each mode; index sums are unsigned.
	always_comb begin
		a.ea = 16'h0000;
		a.target = a.pcn;
		case (a.mode)
			caom_pkg::AM_DIR_S, caom_pkg::AM_BIT_D, caom_pkg::AM_BIT_R: begin
				a.ea = {caom_pkg::PAGE0_HI, a.b0};
			end
			caom_pkg::AM_DIR_L: begin
				a.ea = {a.b0, a.b1};
			end
			caom_pkg::AM_IDX0: begin
				a.ea = {caom_pkg::PAGE0_HI, a.idx};
			end
			caom_pkg::AM_IDX_S: begin
				a.ea = 16'(a.b0) + 16'(a.idx);
			end
			caom_pkg::AM_IDX_L: begin
				a.ea = {a.b0, a.b1} + 16'(a.idx);
			end
			caom_pkg::AM_IND_S, caom_pkg::AM_BIT_I: begin
				a.ea = {caom_pkg::PAGE0_HI, a.p0};
			end
			caom_pkg::AM_IND_L: begin
				a.ea = {a.p0, a.p1};
			end
			caom_pkg::AM_IIX_S: begin
				a.ea = 16'(a.p0) + 16'(a.idx);
			end
			caom_pkg::AM_IIX_L: begin
				a.ea = {a.p0, a.p1} + 16'(a.idx);
			end
			caom_pkg::AM_REL_D: begin
				a.target = caom_pkg::rel_target(a.pcn, a.b0);
			end
			caom_pkg::AM_REL_I: begin
				a.target = caom_pkg::rel_target(a.pcn, a.p0);
			end
			caom_pkg::AM_BIT_RI: begin
				a.ea = {caom_pkg::PAGE0_HI, a.p0};
				a.target = caom_pkg::rel_target(a.pcn, a.b1);
			end
			default: begin
				a.ea = 16'h0000;
			end
		endcase
		// Bit-relative target uses the second fetched byte.
		if (a.mode == caom_pkg::AM_BIT_R) begin
			a.target = caom_pkg::rel_target(a.pcn, a.b1);
		end
	end

endmodule

//--- src/caom_core.sv
// Purpose: Operand addressing-mode engine of an 8-bit core: fetches the
//          bytes after an opcode, reads pointers and forms the address.
// Assumes: One memory read port shared by program and data space.
// Notes:   PC_I is the opcode address; any prefix lies before it.
// What this block does
// - Short forms other than the indexed ones give operand addresses inside page zero only.
// - Long forms reach the whole 64 Kbyte space using more bytes.
// - Read-modify-write operations are refused only with long forms.
// - Inherent instructions are one byte and fetch no operand bytes.
// - Immediate instructions are two bytes; second byte is the operand.
// - Short direct fetches one byte and uses it as the address.
// - Long direct fetches a two-byte address word.
// - Indexed address is the unsigned sum of index and offset.
// - Indexed without offset uses the index register alone.
// - Short indexed adds a byte offset without truncation, up to 1FE.
// - Long indexed adds a word offset to the index register.
// - Short indirect reads a byte pointer from page zero.
// - Long indirect reads a word pointer from page zero.
// - Relative range is -128 to +127 from the following instruction.
// - Relative adds a signed byte, fetched directly or via memory.
// - Indirect indexed adds the index to a pointer read from memory.
// - Prefix 92 turns direct or indexed forms into indirect forms.
// - Prefix 90 selects the alternate index and adds one byte.
`timescale 1ns/1ps
module caom_core #(
	parameter int ADDR_W = 16
) (
	// Clock and reset.
	input wire logic REF_CLK_I,
	input wire logic SYS_RST_I,
	// Decode request from the opcode stage.
	input wire logic START_I,
	input wire caom_pkg::caom_mode_e MODE_I,
	input wire logic [7:0] PREFIX_I,
	input wire logic RMW_I,
	input wire logic [15:0] PC_I,
	input wire logic [7:0] X_I,
	input wire logic [7:0] Y_I,
	// Memory read port.
	output logic MEM_REQ_O,
	output logic [15:0] MEM_ADDR_O,
	input wire logic [7:0] MEM_RDATA_I,
	input wire logic MEM_ACK_I,
	// Result.
	output logic BUSY_O,
	output logic DONE_O,
	output logic REJECT_O,
	output logic [15:0] EA_O,
	output logic [15:0] TARGET_O,
	output logic [7:0] OPERAND_O,
	output logic [2:0] LEN_O
);

	// Only a 16-bit address space is served.
	if (ADDR_W != 16) begin : g_chk
		$error("caom_core supports ADDR_W of 16 only");
	end

	typedef enum logic [1:0] {ST_IDLE, ST_FETCH, ST_PTR, ST_CALC} caom_st_e;

	caom_st_e state_reg, state_next;
	caom_pkg::caom_mode_e mode_reg, mode_next, start_mode;
	logic [7:0] idx_reg, idx_next, b0_reg, b0_next, b1_reg, b1_next;
	logic [7:0] p0_reg, p0_next, p1_reg, p1_next;
	logic [15:0] pcn_reg, pcn_next, addr_reg, addr_next;
	logic [15:0] ea_reg, ea_next, tgt_reg, tgt_next;
	logic [7:0] opd_reg, opd_next;
	logic [1:0] nf_reg, nf_next, np_reg, np_next, cnt_reg, cnt_next;
	logic [1:0] start_nf, start_np;
	logic [2:0] len_reg, len_next;
	logic req_reg, req_next, done_reg, done_next, rej_reg, rej_next;
	logic busy_reg, busy_next;
	logic pfx_ind, pfx_alt, start_rej, take;

	caom_agen_if ag ();

	caom_agen u_agen (
		.a(ag)
	);

	// Prefix decode and start-time mode resolution.
	assign pfx_ind = (PREFIX_I == caom_pkg::PFX_INDIRECT);
	assign pfx_alt = (PREFIX_I == caom_pkg::PFX_ALTERNATE);
	assign start_mode = pfx_ind ? caom_pkg::with_indirect(MODE_I) : MODE_I;
	assign start_nf = caom_pkg::fetch_count(start_mode);
	assign start_np = caom_pkg::ptr_count(start_mode);
	assign start_rej = RMW_I && caom_pkg::is_long(start_mode);
	assign take = req_reg && MEM_ACK_I;

	// Gathered bytes feed the address adder.
	assign ag.mode = mode_reg;
	assign ag.b0 = b0_reg;
	assign ag.b1 = b1_reg;
	assign ag.p0 = p0_reg;
	assign ag.p1 = p1_reg;
	assign ag.idx = idx_reg;
	assign ag.pcn = pcn_reg;

	// Sequencer next-state and datapath next values.
	always_comb begin
		state_next = state_reg;
		mode_next = mode_reg;
		idx_next = idx_reg;
		b0_next = b0_reg;
		b1_next = b1_reg;
		p0_next = p0_reg;
		p1_next = p1_reg;
		pcn_next = pcn_reg;
		addr_next = addr_reg;
		ea_next = ea_reg;
		tgt_next = tgt_reg;
		opd_next = opd_reg;
		nf_next = nf_reg;
		np_next = np_reg;
		cnt_next = cnt_reg;
		len_next = len_reg;
		req_next = req_reg;
		done_next = 1'b0;
		rej_next = rej_reg;
		unique case (state_reg)
			ST_IDLE: begin
				if (START_I) begin
					mode_next = start_mode;
					idx_next = pfx_alt ? Y_I : X_I;
					pcn_next = PC_I + 16'(start_nf) + caom_pkg::ADDR_STEP;
					nf_next = start_nf;
					np_next = start_np;
					cnt_next = 2'h0;
					len_next = caom_pkg::OPC_LEN + 3'(start_nf)
						+ 3'(pfx_ind || pfx_alt);
					if (start_rej) begin
						done_next = 1'b1;
						rej_next = 1'b1;
					end else if (start_nf == 2'h0) begin
						state_next = ST_CALC;
					end else begin
						state_next = ST_FETCH;
						req_next = 1'b1;
						addr_next = PC_I + caom_pkg::ADDR_STEP;
					end
				end
			end
			ST_FETCH: begin
				if (take) begin
					if (cnt_reg == 2'h0) begin
						b0_next = MEM_RDATA_I;
					end else begin
						b1_next = MEM_RDATA_I;
					end
					if (cnt_reg == nf_reg - 2'h1) begin
						cnt_next = 2'h0;
						if (np_reg != 2'h0) begin
							state_next = ST_PTR;
							addr_next = {caom_pkg::PAGE0_HI,
								(cnt_reg == 2'h0) ? MEM_RDATA_I : b0_reg};
						end else begin
							state_next = ST_CALC;
							req_next = 1'b0;
						end
					end else begin
						cnt_next = cnt_reg + 2'h1;
						addr_next = addr_reg + caom_pkg::ADDR_STEP;
					end
				end
			end
			ST_PTR: begin
				if (take) begin
					if (cnt_reg == 2'h0) begin
						p0_next = MEM_RDATA_I;
					end else begin
						p1_next = MEM_RDATA_I;
					end
					if (cnt_reg == np_reg - 2'h1) begin
						state_next = ST_CALC;
						req_next = 1'b0;
					end else begin
						cnt_next = cnt_reg + 2'h1;
						addr_next = {caom_pkg::PAGE0_HI,
							addr_reg[7:0] + caom_pkg::BYTE_STEP};
					end
				end
			end
			ST_CALC: begin
				ea_next = ag.ea;
				tgt_next = ag.target;
				opd_next = b0_reg;
				done_next = 1'b1;
				rej_next = 1'b0;
				state_next = ST_IDLE;
			end
		endcase
		busy_next = (state_next != ST_IDLE);
	end

	// Registers of the sequencer and datapath.
	always_ff @(posedge REF_CLK_I) begin
		if (SYS_RST_I) begin
			state_reg <= ST_IDLE;
			mode_reg <= caom_pkg::AM_INH;
			idx_reg <= 8'h00;
			b0_reg <= 8'h00;
			b1_reg <= 8'h00;
			p0_reg <= 8'h00;
			p1_reg <= 8'h00;
			pcn_reg <= 16'h0000;
			addr_reg <= 16'h0000;
			ea_reg <= 16'h0000;
			tgt_reg <= 16'h0000;
			opd_reg <= 8'h00;
			nf_reg <= 2'h0;
			np_reg <= 2'h0;
			cnt_reg <= 2'h0;
			len_reg <= 3'h0;
			req_reg <= 1'b0;
			done_reg <= 1'b0;
			rej_reg <= 1'b0;
			busy_reg <= 1'b0;
		end else begin
			state_reg <= state_next;
			mode_reg <= mode_next;
			idx_reg <= idx_next;
			b0_reg <= b0_next;
			b1_reg <= b1_next;
			p0_reg <= p0_next;
			p1_reg <= p1_next;
			pcn_reg <= pcn_next;
			addr_reg <= addr_next;
			ea_reg <= ea_next;
			tgt_reg <= tgt_next;
			opd_reg <= opd_next;
			nf_reg <= nf_next;
			np_reg <= np_next;
			cnt_reg <= cnt_next;
			len_reg <= len_next;
			req_reg <= req_next;
			done_reg <= done_next;
			rej_reg <= rej_next;
			busy_reg <= busy_next;
		end
	end

	// Outputs straight from flip-flops.
	assign MEM_REQ_O = req_reg;
	assign MEM_ADDR_O = addr_reg;
	assign BUSY_O = busy_reg;
	assign DONE_O = done_reg;
	assign REJECT_O = rej_reg;
	assign EA_O = ea_reg;
	assign TARGET_O = tgt_reg;
	assign OPERAND_O = opd_reg;
	assign LEN_O = len_reg;

	// Checks on the sequencer and results.
	default clocking cb @(posedge REF_CLK_I); endclocking
	default disable iff (SYS_RST_I);

	sequence s_start_ok;
		state_reg == ST_IDLE && START_I && !start_rej;
	endsequence
	sequence s_start_inh;
		s_start_ok and start_mode == caom_pkg::AM_INH;
	endsequence
	sequence s_start_long;
		s_start_ok and start_mode == caom_pkg::AM_DIR_L;
	endsequence

	property p_page0;
		DONE_O && !REJECT_O && mode_reg inside {caom_pkg::AM_DIR_S,
			caom_pkg::AM_IDX0, caom_pkg::AM_IND_S, caom_pkg::AM_BIT_D}
		|-> EA_O[15:8] == caom_pkg::PAGE0_HI;
	endproperty
	a_page0: assert property (p_page0)
		else $error("short form left page zero");

	property p_reject;
		state_reg == ST_IDLE && START_I && start_rej
		|=> DONE_O && REJECT_O && !MEM_REQ_O;
	endproperty
	a_reject: assert property (p_reject)
		else $error("long read-modify-write not refused");

	property p_inh;
		s_start_inh |=> !MEM_REQ_O ##1 DONE_O && !MEM_REQ_O;
	endproperty
	a_inh: assert property (p_inh)
		else $error("inherent form fetched a byte");

	property p_imm;
		DONE_O && !REJECT_O && mode_reg == caom_pkg::AM_IMM
		|-> OPERAND_O == b0_reg && LEN_O inside {3'h2, 3'h3};
	endproperty
	a_imm: assert property (p_imm)
		else $error("immediate operand or length wrong");

	property p_long_fetch;
		s_start_long |=> MEM_REQ_O
			&& MEM_ADDR_O == $past(PC_I) + caom_pkg::ADDR_STEP;
	endproperty
	a_long_fetch: assert property (p_long_fetch)
		else $error("long direct fetch not at opcode plus one");

	property p_idx_short;
		DONE_O && !REJECT_O && mode_reg == caom_pkg::AM_IDX_S
		|-> EA_O == 16'(b0_reg) + 16'(idx_reg)
			&& EA_O <= caom_pkg::IDX_SHORT_MAX;
	endproperty
	a_idx_short: assert property (p_idx_short)
		else $error("short indexed address wrong");

	property p_idx_long;
		DONE_O && !REJECT_O && mode_reg == caom_pkg::AM_IDX_L
		|-> EA_O == {b0_reg, b1_reg} + 16'(idx_reg);
	endproperty
	a_idx_long: assert property (p_idx_long)
		else $error("long indexed address wrong");

	property p_ptr_page0;
		state_reg == ST_PTR && MEM_REQ_O
		|-> MEM_ADDR_O[15:8] == caom_pkg::PAGE0_HI;
	endproperty
	a_ptr_page0: assert property (p_ptr_page0)
		else $error("pointer read outside page zero");

	property p_rel;
		DONE_O && !REJECT_O && mode_reg == caom_pkg::AM_REL_D
		|-> TARGET_O - pcn_reg + caom_pkg::REL_BIAS <= caom_pkg::REL_SPAN;
	endproperty
	a_rel: assert property (p_rel)
		else $error("relative target out of range");

endmodule

//--- tb/caom_mem_model.sv
// Purpose: Behavioural program and data memory behind the engine.
// Assumes: One read port; requests are held until acknowledged.
// Notes:   Read data outside an answer is scrambled on purpose.
`timescale 1ns/1ps
module caom_mem_model (
	// Clock and answer lag.
	input wire logic clk_i,
	input wire logic [1:0] lag_i,
	// Read port facing the engine.
	input wire logic req_i,
	input wire logic [15:0] addr_i,
	output logic ack_o,
	output logic [7:0] rdata_o
);
	logic [7:0] mem [0:65535];
	int waited;

	// Idle values at time zero.
	initial begin
		ack_o = 1'b0;
		rdata_o = 8'h00;
		waited = 0;
	end

	// Answers a held request after lag_i idle cycles; data is invalid else.
	always @(posedge clk_i) begin
		#1;
		if (req_i && waited >= int'(lag_i)) begin
			ack_o = 1'b1;
			rdata_o = mem[addr_i];
			waited = 0;
		end else begin
			ack_o = 1'b0;
			rdata_o = ~rdata_o;
			waited = req_i ? waited + 1 : 0;
		end
	end
endmodule

//--- tb/test_cpu_operand_address_modes.sv
// Purpose: Self-checking bench for the operand addressing-mode engine.
// Assumes: Expected results come from an integer model of each mode.
// Notes:   Every mode, prefix and read-modify-write flag is exercised.
`timescale 1ns/1ps
module test_cpu_operand_address_modes;
	logic clk, rst, start, rmw, ack, mreq, busy, done, rej;
	caom_pkg::caom_mode_e mode;
	logic [7:0] pfx, xv, yv, rdata, operand;
	logic [15:0] pc, maddr, ea, tgt;
	logic [2:0] len;
	logic [1:0] lag;
	logic [7:0] pfxs [4] = '{8'h00, 8'h92, 8'h90, 8'h3C};
	int mismatches, compares, reads;

	caom_core i_dut (.REF_CLK_I(clk), .SYS_RST_I(rst), .START_I(start),
		.MODE_I(mode), .PREFIX_I(pfx), .RMW_I(rmw), .PC_I(pc), .X_I(xv),
		.Y_I(yv), .MEM_REQ_O(mreq), .MEM_ADDR_O(maddr),
		.MEM_RDATA_I(rdata), .MEM_ACK_I(ack), .BUSY_O(busy),
		.DONE_O(done), .REJECT_O(rej), .EA_O(ea), .TARGET_O(tgt),
		.OPERAND_O(operand), .LEN_O(len));

	caom_mem_model i_mem (.clk_i(clk), .lag_i(lag), .req_i(mreq),
		.addr_i(maddr), .ack_o(ack), .rdata_o(rdata));

	// Clock at 200 MHz.
	initial begin
		clk = 1'b0;
		forever #2.5 clk = ~clk;
	end

	// Counts bytes taken from memory.
	always @(posedge clk) begin
		if (mreq === 1'b1 && ack === 1'b1) begin
			reads++;
		end
	end

	// Compares one value and reports a difference.
	task automatic chk(input string nm, input logic [15:0] exp,
		input logic [15:0] got);
		compares++;
		if (got !== exp) begin
			mismatches++;
			$display("mismatch %s expected %h seen %h", nm, exp, got);
		end
	endtask

	// Prints the counts and the verdict, then stops.
	task automatic complete_run();
		$display("compares %0d mismatches %0d", compares, mismatches);
		if (mismatches == 0 && compares > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask

	function automatic int sx(input int v);
		return v > 127 ? v - 256 : v;
	endfunction

	// Runs one decode and compares it with the integer model.
	task automatic run_op(input int md, input logic [7:0] pf,
		input logic rm, input logic [15:0] pa, input logic [7:0] x,
		input logic [7:0] y);
		int m, nf, np, ix, b0, b1, p0, p1, pcn, e, t, to;
		logic bad;
		logic [15:0] ea_old;
		m = md;
		if (pf == 8'h92) begin
			case (md)
				2: m = 7;
				3: m = 8;
				5: m = 9;
				6: m = 10;
				11: m = 12;
				13: m = 14;
				15: m = 16;
				default: m = md;
			endcase
		end
		nf = (m == 0 || m == 4) ? 0 : (m inside {3, 6, 15, 16}) ? 2 : 1;
		np = (m == 8 || m == 10) ? 2 : (m inside {7, 9, 12, 14, 16}) ? 1 : 0;
		ix = (pf == 8'h90) ? y : x;
		b0 = i_mem.mem[16'(pa + 1)];
		b1 = i_mem.mem[16'(pa + 2)];
		p0 = i_mem.mem[b0];
		p1 = i_mem.mem[(b0 + 1) % 256];
		pcn = (pa + 1 + nf) % 65536;
		case (m)
			2, 13, 15: e = b0;
			3: e = b0 * 256 + b1;
			4: e = ix;
			5: e = b0 + ix;
			6: e = (b0 * 256 + b1 + ix) % 65536;
			7, 14, 16: e = p0;
			8: e = p0 * 256 + p1;
			9: e = p0 + ix;
			10: e = (p0 * 256 + p1 + ix) % 65536;
			default: e = -1;
		endcase
		t = pcn + (m == 11 ? sx(b0) : m == 12 ? sx(p0) :
			(m == 15 || m == 16) ? sx(b1) : 0);
		bad = rm && (m inside {3, 6, 8, 10});
		ea_old = ea;
		mode = caom_pkg::caom_mode_e'(md);
		pfx = pf;
		rmw = rm;
		pc = pa;
		xv = x;
		yv = y;
		reads = 0;
		start = 1'b1;
		@(posedge clk);
		#1 start = 1'b0;
		chk("busy", 16'(!bad), 16'(busy));
		if (!bad) begin
			chk("len", 16'(1 + nf + ((pf == 8'h92 || pf == 8'h90) ? 1 : 0)),
				16'(len));
		end
		for (to = 0; to < 60 && done !== 1'b1; to++) begin
			@(posedge clk);
			#1;
		end
		if (to == 60) begin
			mismatches++;
			$display("mismatch done expected 1 seen %b", done);
			complete_run();
		end
		chk("reject", 16'(bad), 16'(rej));
		chk("busy_end", 16'h0000, 16'(busy));
		chk("reads", 16'(bad ? 0 : nf + np), 16'(reads));
		if (bad) begin
			chk("ea_kept", ea_old, ea);
		end else begin
			if (e >= 0) begin
				chk("ea", 16'(e), ea);
			end
			chk("target", 16'(t), tgt);
			if (m == 1) begin
				chk("operand", 16'(b0), 16'(operand));
			end
		end
		// The result strobe lasts a single cycle.
		@(posedge clk);
		#1;
		chk("done_pulse", 16'h0000, 16'(done));
	endtask

	// Main sequence.
	initial begin
		rst = 1'b1;
		start = 1'b0;
		mode = caom_pkg::AM_INH;
		pfx = 8'h00;
		rmw = 1'b0;
		pc = 16'h0000;
		xv = 8'h00;
		yv = 8'h00;
		lag = 2'h0;
		mismatches = 0;
		compares = 0;
		reads = 0;
		void'($urandom(3));
		for (int i = 0; i < 65536; i++) begin
			i_mem.mem[i] = 8'($urandom);
		end
		repeat (2) @(posedge clk);
		#1 rst = 1'b0;
		chk("reset_outputs", 16'h0000, {busy, done, mreq, rej, ea[11:0]});
		chk("reset_ea", 16'h0000, ea);
		chk("reset_target", 16'h0000, tgt);
		chk("reset_len_opd", 16'h0000, {5'h00, len, operand});
		// Every mode with every prefix kind, plain and read-modify-write.
		for (int m = 0; m < 17; m++) begin
			for (int p = 0; p < 4; p++) begin
				for (int r = 0; r < 2; r++) begin
					lag = 2'($urandom_range(2));
					run_op(m, pfxs[p], r[0], 16'($urandom), 8'($urandom),
						8'($urandom));
				end
			end
		end
		// Short indexed at its highest reach.
		i_mem.mem[16'h1001] = 8'hFF;
		run_op(5, 8'h00, 1'b0, 16'h1000, 8'hFF, 8'h00);
		// Relative displacement at both ends of its range.
		i_mem.mem[16'h2001] = 8'h80;
		run_op(11, 8'h00, 1'b0, 16'h2000, 8'h00, 8'h00);
		i_mem.mem[16'h2001] = 8'h7F;
		run_op(11, 8'h00, 1'b0, 16'h2000, 8'h00, 8'h00);
		// Word pointer at the top of page zero wraps its low byte.
		i_mem.mem[16'h3001] = 8'hFF;
		run_op(3, 8'h92, 1'b0, 16'h3000, 8'h00, 8'h00);
		// A second reset in mid-run clears the flags, the low 12 bits of the address and the target again.
		rst = 1'b1;
		repeat (2) @(posedge clk);
		#1 rst = 1'b0;
		chk("reset_again", 16'h0000, {busy, done, mreq, rej, ea[11:0]});
		chk("reset_again_tgt", 16'h0000, tgt);
		// Random traffic with varying memory lag.
		for (int k = 0; k < 150; k++) begin
			lag = 2'($urandom_range(2));
			run_op(int'($urandom_range(16)), pfxs[$urandom_range(3)],
				1'($urandom), 16'($urandom), 8'($urandom), 8'($urandom));
		end
		complete_run();
	end
endmodule
